/* File: hw/prw_pkg.sv */
// Purpose: constants for the processor reset watchdog block
// Assumes: 200 MHz mclk_i, AHB-Lite word registers
// Notes:   offsets are byte addresses, one aligned word each
package prw_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_WDT_SUP   = 8'h00;
  localparam logic [7:0] ADDR_WDT_FE    = 8'h04;
  localparam logic [7:0] ADDR_CTRL      = 8'h08;
  localparam logic [7:0] ADDR_CAUSE     = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h14;
  localparam logic [7:0] ADDR_MON       = 8'h18;
  // control register fields
  localparam int CTRL_FE_RST    = 0;
  localparam int CTRL_RAD_EN    = 1;
  localparam int CTRL_BOM_EN    = 2;
  localparam int CTRL_IGNORE    = 3;
  localparam int CTRL_FE_WDT_EN = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0006; // monitors armed
  // cause register fields
  localparam int CAUSE_WDT = 0;
  localparam int CAUSE_CMD = 1;
  localparam int CAUSE_FE_WDT = 2;
  // interrupt event bits
  localparam int EV_RAD_SET   = 0;
  localparam int EV_RAD_CLR   = 1;
  localparam int EV_BOM_SET   = 2;
  localparam int EV_BOM_CLR   = 3;
  localparam int EV_FE_WDT    = 4;
  localparam int EV_STANDBY   = 5;
  localparam int EV_W = 6;
  // monitor status fields
  localparam int MON_RAD = 0;
  localparam int MON_BOM = 1;
  localparam int MON_SHUT = 2;
  localparam int MON_STBY = 3;
  // serial command word
  localparam int CMD_W = 16;
  localparam int CMD_RST_BIT = 0;
  // reset stretch width
  localparam int RST_WIDTH_NS = 1000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int RST_CYC = (RST_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ahb
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] HSIZE_WORD = 3'b010;
endpackage

/* File: hw/prw_top.sv */
// Purpose: reset, watchdog and monitor logic of the processor assembly
// Assumes: strobe, monitor and standby pins pass a three-flop synchroniser; AHB-Lite register slave
// Notes:   all outputs are registered; clock enable freezes all state but reset loads, which act while it is low
//
// Contract
// - supervisory reset from power-on, watchdog expiry or command pulse.
// - watchdog is a 32-bit counter readable and writable by software.
// - reset loads preset; counter decrements until reloaded or expired.
// - watchdog terminal count drives board reset without software.
// - discrete reset is one pulse bit inside a 16-bit command word.
// - watchdog and command resets stretched to longest required width.
// - latched cause bits show watchdog or command reset origin.
// - front-end reset from power-on, own watchdog or supervisory wire.
// - front-end power-on and watchdog behave like supervisory ones.
// - front-end reset wire set by a read/write control register bit.
// - radiation set by default issues detector power shutdown.
// - monitor response programmable, can ignore monitor signals.
// - bright-object monitor handled like radiation monitor.
// - standby on spacecraft command, gating front-end power and clocks.
//
// Decided for this implementation: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module prw_top #(
  parameter logic [31:0] WDT_PRESET = 32'h0100_0000,
  parameter int          RST_CYC    = prw_pkg::RST_CYC
) (
  // clock, reset, enable
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  input  wire logic        ce_i,
  // ahb-lite slave
  input  wire logic        hsel_i,
  input  wire logic [7:0]  haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // serial command word from command unit
  input  wire logic [15:0] cmd_word_i,
  input  wire logic        cmd_strobe_i,
  // spacecraft monitor and standby pins
  input  wire logic        rad_set_i,
  input  wire logic        rad_clr_i,
  input  wire logic        bom_set_i,
  input  wire logic        bom_clr_i,
  input  wire logic        standby_i,
  // resets and controls out
  output logic             sup_rst_o,
  output logic             fe_rst_o,
  output logic             det_shutdown_o,
  output logic             fe_power_off_o,
  output logic             clk_stop_o,
  output logic             irq_o
);
  localparam int SYNC_N = 6;
  localparam int CW = $clog2(RST_CYC + 1);
  localparam int EV_W_L = prw_pkg::EV_W;
  // bit positions of the pins inside the synchroniser vector
  localparam int P_RAD_SET = 0;
  localparam int P_RAD_CLR = 1;
  localparam int P_BOM_SET = 2;
  localparam int P_BOM_CLR = 3;
  localparam int P_CMD_STB = 4;
  localparam int P_STANDBY = 5;

  // three-flop synchronisers for the asynchronous pins
  // the first stage may go metastable, so only the second and
  // third stages are ever compared; a pin pulse shorter than two
  // clocks may be lost, so the far side must hold its pins longer
  logic [SYNC_N-1:0] s1_r;
  logic [SYNC_N-1:0] s2_r;
  logic [SYNC_N-1:0] s3_r;
  wire  [SYNC_N-1:0] pin_raw = {standby_i, cmd_strobe_i,
                                bom_clr_i, bom_set_i, rad_clr_i, rad_set_i};
  // change counts only once second and third stages agree
  logic [SYNC_N-1:0] lvl_r;
  wire  [SYNC_N-1:0] lvl_nxt = (s2_r == s3_r) ? s3_r : lvl_r;
  wire  [SYNC_N-1:0] rise = lvl_nxt & ~lvl_r;
  // command word is a level, sampled each clock, used on strobe edge
  logic [15:0] cmd_word_r;

  // registers, each one aligned word on the bus
  // 00 supervisory watchdog, 04 front-end watchdog, 08 control,
  // 0c reset cause, 10 event status (write one to clear),
  // 14 event mask, 18 monitor and standby state (read only)
  // watchdog, control, mask and status return to defaults on any
  // supervisory reset; only the cause bits wait for power-on to clear
  logic [31:0] wdt_sup_r;
  logic [31:0] wdt_fe_r;
  logic [31:0] ctrl_r;
  logic [2:0]  cause_r;
  logic [EV_W_L-1:0] stat_r;
  logic [EV_W_L-1:0] mask_r;
  logic        rad_r;
  logic        bom_r;
  logic        shut_r;
  logic        stby_r;
  // stretch counters, nonzero while a board is held in reset
  logic [CW-1:0] sup_cnt_r;
  logic [CW-1:0] fe_cnt_r;

  // ahb address phase capture
  // writes land at the end of the data phase, from the captured
  // address; reads decode the live address phase, so read data
  // leaves a flop without costing a wait state
  // non-word sizes are never taken: no write, and read data zero
  logic        ph_wr_r;
  logic [7:0]  ph_addr_r;
  wire acc = hsel_i & hready_i & (htrans_i == prw_pkg::HTRANS_NONSEQ)
             & (hsize_i == prw_pkg::HSIZE_WORD);
  wire rd = acc & ~hwrite_i;
  wire wr = ph_wr_r;
  // write strobe per register, from the captured address
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = wr && (a == o);
  endfunction
  wire w_wdt_sup = hit(ph_addr_r, prw_pkg::ADDR_WDT_SUP);
  wire w_wdt_fe  = hit(ph_addr_r, prw_pkg::ADDR_WDT_FE);
  wire w_ctrl    = hit(ph_addr_r, prw_pkg::ADDR_CTRL);
  wire w_stat    = hit(ph_addr_r, prw_pkg::ADDR_IRQ_STAT);
  wire w_mask    = hit(ph_addr_r, prw_pkg::ADDR_IRQ_MASK);

  // watchdog terminal counts
  // the count stops at zero, the front-end one only while enabled in
  // control; a terminal count stays up until the board reset that it causes reloads the preset
  wire sup_tc = (wdt_sup_r == 32'h0000_0000);
  wire fe_tc  = ctrl_r[prw_pkg::CTRL_FE_WDT_EN]
                & (wdt_fe_r == 32'h0000_0000);
  // command reset pulse bit in the 16-bit word
  // the word counts only on the strobe edge; changes while the
  // strobe is low do nothing
  wire cmd_rst = rise[P_CMD_STB] & cmd_word_r[prw_pkg::CMD_RST_BIT];
  // a board stays in reset while its stretch counter runs
  wire sup_busy = (sup_cnt_r != '0);
  wire fe_busy  = (fe_cnt_r != '0);
  // board resets: any source resets the whole board
  wire sup_rst_any = ~resetn_i | sup_busy;
  wire fe_rst_any  = sup_rst_any | fe_busy
                     | ctrl_r[prw_pkg::CTRL_FE_RST];

  // monitor decode; ignore mode drops every monitor event
  // set and clear come on separate pins, state keeps the last edge;
  // set and clear in one cycle leave the state set
  // ignore freezes the state: a shutdown already on stays on
  wire ign = ctrl_r[prw_pkg::CTRL_IGNORE];
  wire rad_on  = rise[P_RAD_SET] & ~ign;
  wire rad_off = rise[P_RAD_CLR] & ~ign;
  wire bom_on  = rise[P_BOM_SET] & ~ign;
  wire bom_off = rise[P_BOM_CLR] & ~ign;
  wire rad_nxt = rad_on | (rad_r & ~rad_off);
  wire bom_nxt = bom_on | (bom_r & ~bom_off);
  wire shut_nxt = (rad_nxt & ctrl_r[prw_pkg::CTRL_RAD_EN])
                  | (bom_nxt & ctrl_r[prw_pkg::CTRL_BOM_EN]);
  wire stby_nxt = lvl_r[P_STANDBY];

  // event vector; set beats a simultaneous write-one clear
  wire [EV_W_L-1:0] ev = {rise[P_STANDBY], fe_tc, bom_off, bom_on,
                          rad_off, rad_on};
  wire [EV_W_L-1:0] stat_nxt =
    (stat_r & ~(w_stat ? hwdata_i[EV_W_L-1:0] : '0)) | ev;

  // read mux on the live address phase
  // a watchdog read returns the count at the address phase edge
  wire [31:0] rd_val =
    (haddr_i == prw_pkg::ADDR_WDT_SUP)  ? wdt_sup_r :
    (haddr_i == prw_pkg::ADDR_WDT_FE)   ? wdt_fe_r :
    (haddr_i == prw_pkg::ADDR_CTRL)     ? ctrl_r :
    (haddr_i == prw_pkg::ADDR_CAUSE)    ? {29'h0, cause_r} :
    (haddr_i == prw_pkg::ADDR_IRQ_STAT) ? {26'h0, stat_r} :
    (haddr_i == prw_pkg::ADDR_IRQ_MASK) ? {26'h0, mask_r} :
    (haddr_i == prw_pkg::ADDR_MON)
      ? {28'h0, stby_r, shut_r, bom_r, rad_r} : 32'h0000_0000;

  // synchronisers
  // clock enable freezes the pin stages too, so pin edges that
  // come and go while it is low are lost to the block
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      lvl_r <= '0;
      cmd_word_r <= 16'h0000;
    end else if (ce_i) begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
      // word must be stable before strobe rises
      cmd_word_r <= cmd_word_i;
    end
  end

  // ahb data phase, zero wait states
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      ph_wr_r <= 1'b0;
      ph_addr_r <= 8'h00;
      hrdata_o <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else if (ce_i) begin
      ph_wr_r <= acc & hwrite_i;
      ph_addr_r <= haddr_i;
      hrdata_o <= rd ? rd_val : 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  // watchdogs: preset on reset, decrement, reload by write
  // a software write wins over the decrement in the same cycle
  // the front-end count only causes a reset once enabled in control
  // a preset of zero would hold a board in reset for good
  always_ff @(posedge mclk_i) begin
    if (sup_rst_any) begin
      wdt_sup_r <= WDT_PRESET;
    end else if (ce_i) begin
      if (w_wdt_sup) wdt_sup_r <= hwdata_i;
      else if (!sup_tc) wdt_sup_r <= wdt_sup_r - 32'h0000_0001;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (fe_rst_any) begin
      wdt_fe_r <= WDT_PRESET;
    end else if (ce_i) begin
      if (w_wdt_fe) wdt_fe_r <= hwdata_i;
      else if (!fe_tc) wdt_fe_r <= wdt_fe_r - 32'h0000_0001;
    end
  end

  // reset stretchers; power-on loads the full width, so outputs stay high past its release
  // a fresh trigger while busy restarts the full width
  // the width is a parameter, set it to the slowest device's need
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      sup_cnt_r <= CW'(RST_CYC);
      fe_cnt_r <= CW'(RST_CYC);
    end else if (ce_i) begin
      if (sup_tc | cmd_rst) sup_cnt_r <= CW'(RST_CYC);
      else if (sup_busy) sup_cnt_r <= sup_cnt_r - CW'(1);
      if (fe_tc) fe_cnt_r <= CW'(RST_CYC);
      else if (fe_busy) fe_cnt_r <= fe_cnt_r - CW'(1);
    end
  end

  // cause bits survive watchdog and command resets, cleared at power-on
  // a watchdog expiry replaces a stale command bit and the reverse
  // the front-end bit gathers until the next supervisory event
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      cause_r <= 3'h0;
    end else if (ce_i) begin
      if (sup_tc & ~sup_busy) cause_r <= 3'h1;
      else if (cmd_rst) cause_r <= 3'h2;
      else if (fe_tc) cause_r[prw_pkg::CAUSE_FE_WDT] <= 1'b1;
    end
  end

  // control, interrupt and monitor state
  // any supervisory reset returns software state to its defaults
  // monitor state restarts clear; pins are then seen afresh
  always_ff @(posedge mclk_i) begin
    if (sup_rst_any) begin
      ctrl_r <= prw_pkg::CTRL_RESET;
      stat_r <= '0;
      mask_r <= '0;
      rad_r <= 1'b0;
      bom_r <= 1'b0;
      shut_r <= 1'b0;
      stby_r <= 1'b0;
    end else if (ce_i) begin
      if (w_ctrl) ctrl_r <= hwdata_i;
      if (w_mask) mask_r <= hwdata_i[EV_W_L-1:0];
      stat_r <= stat_nxt;
      rad_r <= rad_nxt;
      bom_r <= bom_nxt;
      shut_r <= shut_nxt;
      stby_r <= stby_nxt;
    end
  end

  // output flops
  // one flop after the decode, so every output is glitch free
  // reset outputs are high through power-on, before counters run
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      sup_rst_o <= 1'b1;
      fe_rst_o <= 1'b1;
      det_shutdown_o <= 1'b0;
      fe_power_off_o <= 1'b0;
      clk_stop_o <= 1'b0;
      irq_o <= 1'b0;
    end else if (ce_i) begin
      sup_rst_o <= sup_rst_any;
      fe_rst_o <= fe_rst_any;
      det_shutdown_o <= shut_r;
      fe_power_off_o <= stby_r;
      clk_stop_o <= stby_r;
      irq_o <= |(stat_r & mask_r);
    end
  end
endmodule

/* File: sim/prw_top_properties.sv */
// Purpose: port timing checks for the reset watchdog block
// Assumes: RST_CYC equals the bound instance's value
// Notes:   pin sync and edge detect take a few cycles
`timescale 1ns/1ps
module prw_props #(
  parameter int RST_CYC = 20
) (
  input wire logic        mclk_i, resetn_i, hreadyout_o, hresp_o,
  input wire logic        cmd_strobe_i, rad_set_i, bom_set_i, standby_i,
  input wire logic [15:0] cmd_word_i,
  input wire logic        sup_rst_o, fe_rst_o, det_shutdown_o,
  input wire logic        fe_power_off_o, clk_stop_o
);
  int n_hi = 0;
  // length of the current reset pulse, kept through resets on purpose
  always_ff @(posedge mclk_i) n_hi <= sup_rst_o ? n_hi + 1 : 0;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  chk_por_hold: assert property ($rose(resetn_i) |->
    (sup_rst_o && fe_rst_o) [*8]) else $error("resets not held");
  chk_rst_stretch: assert property ($fell(sup_rst_o) |->
    n_hi >= RST_CYC) else $error("reset pulse too short");
  chk_cmd_reset: assert property ($rose(cmd_strobe_i) &&
    cmd_word_i[0] |-> ##[1:12] sup_rst_o) else $error("no cmd reset");
  chk_cmd_quiet: assert property ($rose(cmd_strobe_i) &&
    !cmd_word_i[0] && !sup_rst_o |=> (!sup_rst_o) [*8])
    else $error("reset without reset bit");
  chk_bus_okay: assert property (hreadyout_o && !hresp_o)
    else $error("bus wait or error");
  chk_rad_shut: assert property ($rose(rad_set_i) |->
    ##[1:12] det_shutdown_o) else $error("no shutdown on rad");
  chk_bom_shut: assert property ($rose(bom_set_i) |->
    ##[1:12] det_shutdown_o) else $error("no shutdown on bright");
  chk_standby_act: assert property ($rose(standby_i) |->
    ##[1:12] (fe_power_off_o || clk_stop_o)) else $error("no standby");
endmodule
bind prw_top prw_props #(.RST_CYC(RST_CYC)) u_prw_props (.*);

/* File: sim/prw_cmd_unit.sv */
// Purpose: command unit and spacecraft pin model
// Assumes: block synchronises every pin but the word, which it samples once per clock
// Notes:   word line shows the inverse once the strobe is over
`timescale 1ns/1ps
module prw_cmd_unit (
  input  wire logic        mclk_i,
  output logic      [15:0] cmd_word_o,
  output logic             cmd_strobe_o,
  output logic      [3:0]  mon_o,
  output logic             standby_o
);
  // quiet pins at time zero
  initial begin
    cmd_word_o = 16'hffff;
    cmd_strobe_o = 1'b0;
    mon_o = 4'h0;
    standby_o = 1'b0;
  end
  // word held well past the sync delay, then no stale copy
  task automatic send(input logic [15:0] w);
    @(posedge mclk_i);
    cmd_word_o <= w;
    @(posedge mclk_i);
    cmd_strobe_o <= 1'b1;
    repeat (2) @(posedge mclk_i);
    cmd_strobe_o <= 1'b0;
    repeat (6) @(posedge mclk_i);
    cmd_word_o <= ~w;
  endtask
  // set and clear come as separate two-cycle events
  task automatic pulse(input int k);
    @(posedge mclk_i);
    mon_o[k] <= 1'b1;
    repeat (2) @(posedge mclk_i);
    mon_o[k] <= 1'b0;
  endtask
  // standby command level
  task automatic stby(input logic v);
    @(posedge mclk_i);
    standby_o <= v;
  endtask
endmodule

/* File: sim/prw_top_tb.sv */
// Purpose: self-checking bench for the reset watchdog block
// Assumes: zero wait state slave, short preset and stretch
// Notes:   irq checked with mask open and with mask closed
`timescale 1ns/1ps
module prw_top_tb;
  localparam int RC = 20;
  localparam logic [31:0] PRE = 32'h0000_0800;
  logic        mclk_i, resetn_i, ce_i, hsel_i, hwrite_i;
  logic [7:0]  haddr_i;
  logic [1:0]  htrans_i;
  logic [2:0]  hsize_i;
  logic [31:0] hwdata_i, hrdata_o, q;
  logic [15:0] cmd_word_i;
  logic        hreadyout_o, hresp_o, cmd_strobe_i, standby_i, sup_rst_o;
  logic        fe_rst_o, det_shutdown_o, fe_power_off_o, clk_stop_o, irq_o;
  wire  [3:0]  mon;
  int          n_errors = 0, n_tests = 0;
  // outputs looked at by the waiting task
  wire  [3:0]  obs = {fe_power_off_o | clk_stop_o, det_shutdown_o,
                      fe_rst_o, sup_rst_o};
  prw_cmd_unit u_prw_cmd_unit (.mclk_i, .cmd_word_o(cmd_word_i),
    .cmd_strobe_o(cmd_strobe_i), .mon_o(mon), .standby_o(standby_i));
  prw_top #(.WDT_PRESET(PRE), .RST_CYC(RC)) u_prw_top (.*,
    .hready_i(hreadyout_o), .rad_set_i(mon[0]), .rad_clr_i(mon[1]),
    .bom_set_i(mon[2]), .bom_clr_i(mon[3]));
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // one single word transfer, address phase then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    hsel_i <= 1'b1;
    haddr_i <= a;
    hwrite_i <= w;
    htrans_i <= prw_pkg::HTRANS_NONSEQ;
    hsize_i <= prw_pkg::HSIZE_WORD;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'b00;
    hwdata_i <= d;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    q = hrdata_o;
  endtask
  // bounded wait for one output to reach a level
  task automatic wt(input int b, input logic v, input int n);
    while (obs[b] !== v && n > 0) begin
      @(posedge mclk_i);
      n--;
    end
    chk(32'(obs[b]), 32'(v));
  endtask
  task automatic t_por;
    resetn_i <= 1'b0;
    repeat (20) @(posedge mclk_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    chk(32'(sup_rst_o & fe_rst_o), 32'h1);
    wt(0, 1'b0, RC + 10);
    wt(1, 1'b0, 10);
    bus(0, prw_pkg::ADDR_CAUSE, 0);
    chk(q & 32'h7, 32'h0);
    $display("test por done");
  endtask
  task automatic t_wdt_rw;
    logic [31:0] s;
    bus(0, prw_pkg::ADDR_WDT_SUP, 0);
    s = q;
    // frozen 40 cycles: the count may only move by the bus cycles
    ce_i <= 1'b0;
    repeat (40) @(posedge mclk_i);
    ce_i <= 1'b1;
    bus(0, prw_pkg::ADDR_WDT_SUP, 0);
    chk(32'(q < s), 32'h1);
    chk(32'(s - q < 32'h0000_0010), 32'h1);
    bus(1, prw_pkg::ADDR_WDT_SUP, 32'hffff_fff0);
    bus(0, prw_pkg::ADDR_WDT_SUP, 0);
    chk(32'(q > 32'hffff_ff00), 32'h1);
    bus(1, prw_pkg::ADDR_WDT_SUP, PRE);
    bus(1, 8'h40, 32'hffff_ffff);
    bus(0, 8'h40, 0);
    chk(q, 32'h0);
    $display("test watchdog access done");
  endtask
  task automatic t_fe;
    bus(1, prw_pkg::ADDR_CTRL, prw_pkg::CTRL_RESET | 32'h1);
    wt(1, 1'b1, 10);
    chk(32'(sup_rst_o), 32'h0);
    bus(0, prw_pkg::ADDR_CTRL, 0);
    chk(q & 32'h1f, prw_pkg::CTRL_RESET | 32'h1);
    bus(1, prw_pkg::ADDR_CTRL, prw_pkg::CTRL_RESET);
    wt(1, 1'b0, RC + 10);
    $display("test frontend wire done");
  endtask
  task automatic t_mon;
    logic [31:0] s;
    u_prw_cmd_unit.pulse(0);
    wt(2, 1'b1, 12);
    bus(0, prw_pkg::ADDR_MON, 0);
    chk(q & 32'h5, 32'h5);
    bus(1, prw_pkg::ADDR_IRQ_MASK, 32'h3f);
    repeat (2) @(posedge mclk_i);
    s = 32'(irq_o);
    bus(1, prw_pkg::ADDR_IRQ_MASK, 32'h0);
    repeat (2) @(posedge mclk_i);
    chk(s, 32'h1);
    chk(32'(irq_o), 32'h0);
    bus(1, prw_pkg::ADDR_IRQ_STAT, 32'h3f);
    bus(0, prw_pkg::ADDR_IRQ_STAT, 0);
    chk(q & 32'h1, 32'h0);
    bus(1, prw_pkg::ADDR_CTRL, prw_pkg::CTRL_RESET | 32'h8);
    u_prw_cmd_unit.pulse(1);
    repeat (4) @(posedge mclk_i);
    bus(0, prw_pkg::ADDR_MON, 0);
    chk(q & 32'h5, 32'h5);
    bus(1, prw_pkg::ADDR_CTRL, prw_pkg::CTRL_RESET);
    u_prw_cmd_unit.pulse(1);
    repeat (4) @(posedge mclk_i);
    bus(0, prw_pkg::ADDR_MON, 0);
    chk(q & 32'h1, 32'h0);
    u_prw_cmd_unit.pulse(2);
    repeat (4) @(posedge mclk_i);
    bus(0, prw_pkg::ADDR_MON, 0);
    chk(q & 32'h2, 32'h2);
    u_prw_cmd_unit.pulse(3);
    u_prw_cmd_unit.stby(1'b1);
    wt(3, 1'b1, 12);
    u_prw_cmd_unit.stby(1'b0);
    wt(3, 1'b0, 12);
    bus(0, prw_pkg::ADDR_MON, 0);
    chk(q & 32'ha, 32'h0);
    $display("test monitors and standby done");
  endtask
  task automatic t_cmd;
    bus(1, prw_pkg::ADDR_WDT_SUP, PRE);
    u_prw_cmd_unit.send(16'hfffe);
    repeat (12) @(posedge mclk_i);
    chk(32'(sup_rst_o), 32'h0);
    u_prw_cmd_unit.send(16'h0001);
    wt(0, 1'b1, 12);
    wt(0, 1'b0, RC + 10);
    bus(0, prw_pkg::ADDR_CAUSE, 0);
    chk(q & 32'h2, 32'h2);
    $display("test command reset done");
  endtask
  task automatic t_wdt;
    wt(0, 1'b1, int'(PRE) + 100);
    wt(0, 1'b0, RC + 10);
    bus(0, prw_pkg::ADDR_CAUSE, 0);
    chk(q & 32'h1, 32'h1);
    $display("test watchdog expiry done");
  endtask
  task automatic final_report;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    resetn_i = 1'b0;
    ce_i = 1'b1;
    hsel_i = 1'b0;
    hwrite_i = 1'b0;
    haddr_i = 8'h00;
    htrans_i = 2'b00;
    hsize_i = 3'b000;
    hwdata_i = 32'h0000_0000;
    t_por;
    t_wdt_rw;
    t_fe;
    t_mon;
    t_cmd;
    t_wdt;
    t_por;
    final_report;
  end
  // hang guard, about eight times the expected run
  initial begin
    #100000;
    n_errors++;
    final_report;
  end
endmodule
